// file: video_source_ctrl.sv
// video_source_ctrl: video source that drives a display controller's 24-bit parallel port
// assumes clk_i at 200 MHz; pixel clock is divided down here and driven out
//
// Contract
// [R1] The device reset line is held low for at least 1.25 us each time it is asserted.
// [R2] The vertical sync pulse stays high for at least one line.
// [R3] At least two lines pass from the vertical sync rise to the sync edge of the first active line.
// [R4] At least one line passes from the line after the last active line to the next vertical sync rise.
// [R5] Front plus back vertical porch spans at least 6 + 8 * max(1, source lines / used display lines).
// [R6] The horizontal sync pulse is high for 4 to 128 pixel clocks.
// [R7] Data-enable rises no sooner than 4 pixel clocks after the horizontal sync rise.
// [R8] At least 8 pixel clocks pass from data-enable falling to the next horizontal sync rise.
// [R9] The stereo reference changes at least 1.0 ms before the vertical sync transition it precedes.
// [R10] The stereo reference stays unchanged for at least 1.0 ms after any vertical sync transition.
// [R11] The display side captures the pixel word only on clocks where data-enable is high.
`timescale 1ns/1ps
`include "video_src_map.svh"
module video_source_ctrl #(
  parameter int PCLK_DIV         = 2,
  parameter int FIFO_DEPTH       = 4,
  parameter int STEREO_GUARD_CYC = `STEREO_GUARD_CYC
) (
  input  wire logic                          clk_i,
  input  wire logic                          rst_n_i,
  input  wire logic                          enable_i,
  input  wire logic                          device_reset_req_i,
  input  wire video_src_pkg::timing_cfg_type cfg_i,
  input  wire logic [11:0]                   display_used_lines_i,
  input  wire logic [23:0]                   pix_word_i,
  input  wire logic                          pix_valid_i,
  output logic                               pix_ready_o,
  input  wire logic                          stereo_eye_i,
  output video_src_pkg::video_pins_type      pins_o,
  output logic                               hw_reset_n_o,
  output logic                               underrun_o,
  output logic                               frame_start_o
);
  import video_src_pkg::*;

  localparam int HALF = PCLK_DIV / 2;

  // pixel clock must sit inside the port's 1..155 MHz range
  initial
  begin
    if (PCLK_DIV < 2 || `CLK_MHZ / PCLK_DIV > `PCLK_MAX_MHZ || `CLK_MHZ / PCLK_DIV < `PCLK_MIN_MHZ)
      $error("video_source_ctrl: PCLK_DIV gives a pixel clock outside the allowed range");
    if (FIFO_DEPTH < 2) $error("video_source_ctrl: FIFO_DEPTH must be >= 2");
    if (STEREO_GUARD_CYC < 1 || STEREO_GUARD_CYC > 1048575) $error("video_source_ctrl: bad STEREO_GUARD_CYC");
  end

  function automatic logic [11:0] max12(input logic [11:0] a, input logic [11:0] b);
    max12 = (a > b) ? a : b;
  endfunction

  // device reset pulse generator
  logic dev_in_reset;
  reset_pulser #(
    .LOW_CYC (`RST_LOW_CYC)
  ) u_reset (
    .clk_i        (clk_i),
    .rst_n_i      (rst_n_i),
    .req_i        (device_reset_req_i),
    .hw_reset_n_o (hw_reset_n_o),
    .busy_o       (dev_in_reset)
  );

  // pixel buffer between the user stream and the port
  logic [23:0] fifo_data;
  logic        fifo_valid;
  logic        fifo_pop;
  pixel_fifo #(
    .WIDTH (`PIXEL_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .in_data_i   (pix_word_i),
    .in_valid_i  (pix_valid_i),
    .in_ready_o  (pix_ready_o),
    .out_data_o  (fifo_data),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_pop)
  );

  // one flop per pin, gathered into the bundle in its field order so each has a single driver
  logic        pin_pclk, pin_vsync, pin_hsync, pin_valid, pin_stereo;
  logic [23:0] pin_word;
  assign pins_o = {pin_pclk, pin_vsync, pin_hsync, pin_valid, pin_word, pin_stereo};

  // pixel clock divider; tick marks the falling pclk edge where outputs change
  logic [7:0] div_cnt;
  logic [7:0] next_div;
  logic       tick;
  assign next_div = (div_cnt == 8'(PCLK_DIV - 1)) ? 8'h00 : div_cnt + 8'h01;
  assign tick     = (next_div == 8'(HALF));

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      div_cnt  <= 8'h00;
      pin_pclk <= 1'b0;
    end
    else
    begin
      div_cnt  <= next_div;
      pin_pclk <= (next_div < 8'(HALF)); // device samples on the rising edge, mid-pixel
    end
  end

  // clamp the requested timing to the port minima
  timing_cfg_type eff;
  timing_cfg_type cfg_q;
  always_comb
  begin
    eff         = cfg_i;
    eff.h_sync  = (cfg_i.h_sync > `HSW_MAX) ? `HSW_MAX : max12(cfg_i.h_sync, `HSW_MIN); // see [R6]
    eff.h_back  = max12(cfg_i.h_back, `HBP_MIN);  // see [R7]
    eff.h_front = max12(cfg_i.h_front, `HFP_MIN); // see [R8]
    eff.h_active = max12(cfg_i.h_active, 12'h001);
    eff.v_active = max12(cfg_i.v_active, 12'h001);
    eff.v_sync  = max12(cfg_i.v_sync, `VSW_MIN);  // see [R2]
    eff.v_back  = max12(max12(cfg_i.v_back, `VBP_MIN), eff.v_sync); // see [R3]
    eff.v_front = max12(cfg_i.v_front, `VFP_MIN); // see [R4]
  end

  // frame position counters
  run_state_type state;
  logic [11:0]   h_cnt;
  logic [15:0]   v_cnt;
  logic [15:0]   h_total;
  logic [15:0]   act_start;
  logic [15:0]   act_end;
  logic          line_end;
  logic          frame_done;
  logic          in_vactive;
  logic          hsync_now;
  logic          vsync_now;
  logic          de_now;

  assign h_total   = 16'(cfg_q.h_sync) + 16'(cfg_q.h_back) + 16'(cfg_q.h_active) + 16'(cfg_q.h_front);
  assign act_start = 16'(cfg_q.h_sync) + 16'(cfg_q.h_back);
  assign act_end   = act_start + 16'(cfg_q.h_active);
  assign line_end  = (16'(h_cnt) == h_total - 16'h0001);
  assign in_vactive = (v_cnt >= 16'(cfg_q.v_back)) && (v_cnt < 16'(cfg_q.v_back) + 16'(cfg_q.v_active));
  assign hsync_now = (state == ST_RUN) && (h_cnt < cfg_q.h_sync);
  assign vsync_now = (state == ST_RUN) && (v_cnt < 16'(cfg_q.v_sync));
  assign de_now    = (state == ST_RUN) && in_vactive && (16'(h_cnt) >= act_start) && (16'(h_cnt) < act_end);

  // minimum total blanking: 6 + 8*max(1, src/used) lines, found by repeated addition
  logic [16:0] tvb_acc;
  logic [16:0] tvb_q;
  logic        tvb_busy;
  logic [16:0] tvb_target;
  logic [16:0] tvb_min;
  logic [11:0] used_lines;
  assign used_lines = (display_used_lines_i == 12'h000) ? eff.v_active : display_used_lines_i;
  assign tvb_target = `TVB_RATIO_MUL * 17'(cfg_q.v_active);
  assign tvb_min    = `TVB_BASE + ((tvb_q > `TVB_RATIO_MUL) ? tvb_q : `TVB_RATIO_MUL); // see [R5]

  logic [11:0] used_q;
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      tvb_acc  <= 17'h00000;
      tvb_q    <= 17'h00000;
      tvb_busy <= 1'b0;
    end
    else if (frame_start_o)
    begin
      tvb_acc  <= 17'h00000;
      tvb_q    <= 17'h00000;
      tvb_busy <= 1'b1;
    end
    else if (tvb_busy)
    begin
      if (tvb_acc >= tvb_target)
        tvb_busy <= 1'b0;
      else
      begin
        tvb_acc <= tvb_acc + 17'(used_q);
        tvb_q   <= tvb_q + 17'h00001;
      end
    end
  end

  // stereo guard timers in system clocks, saturating
  logic [19:0] since_vs;
  logic [19:0] since_stereo;
  logic        stereo_ok_to_change;
  logic        stereo_guard_met;
  assign stereo_guard_met    = (since_stereo >= 20'(STEREO_GUARD_CYC));
  assign stereo_ok_to_change = (since_vs >= 20'(STEREO_GUARD_CYC)) && !vsync_now && !pins_o.vsync; // see [R10]

  // a frame may close only when porches, blanking, ratio search and stereo setup are all satisfied
  logic [15:0] lines_after;
  assign lines_after = v_cnt + 16'h0001 - 16'(cfg_q.v_back) - 16'(cfg_q.v_active);
  assign frame_done  = (v_cnt + 16'h0001 >= 16'(cfg_q.v_back) + 16'(cfg_q.v_active))
                       && (lines_after >= 16'(cfg_q.v_front))                       // see [R4]
                       && (17'(lines_after) + 17'(cfg_q.v_back) >= tvb_min)          // see [R5]
                       && !tvb_busy
                       && stereo_guard_met;                                          // see [R9]

  // run control and counters advance once per pixel
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state         <= ST_IDLE;
      h_cnt         <= 12'h000;
      v_cnt         <= 16'h0000;
      cfg_q         <= '0;
      used_q        <= 12'h001;
      frame_start_o <= 1'b0;
    end
    else
    begin
      frame_start_o <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          if (tick && enable_i && !dev_in_reset && stereo_guard_met) // see [R9]
          begin
            state         <= ST_RUN;
            cfg_q         <= eff;
            used_q        <= used_lines;
            h_cnt         <= 12'h000;
            v_cnt         <= 16'h0000;
            frame_start_o <= 1'b1;
          end
        end
        ST_RUN:
        begin
          if (dev_in_reset)
            state <= ST_IDLE; // never drive video into a controller held in reset
          else if (tick)
          begin
            if (!line_end)
              h_cnt <= h_cnt + 12'h001;
            else
            begin
              h_cnt <= 12'h000;
              if (!frame_done)
                v_cnt <= v_cnt + 16'h0001; // extra blank lines stretch the front porch
              else if (!enable_i)
                state <= ST_IDLE; // stop only on a frame boundary
              else
              begin
                v_cnt         <= 16'h0000;
                cfg_q         <= eff; // new timing takes effect only between frames
                used_q        <= used_lines;
                frame_start_o <= 1'b1;
              end
            end
          end
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // pin registers follow the counters one pixel later, updated on the falling pclk edge
  assign fifo_pop = tick && de_now && fifo_valid;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      pin_hsync <= 1'b0;
      pin_vsync <= 1'b0;
      pin_valid <= 1'b0;
      pin_word  <= 24'h000000;
    end
    else if (tick)
    begin
      pin_hsync <= hsync_now; // see [R6]
      pin_vsync <= vsync_now; // see [R2]
      pin_valid <= de_now;    // see [R7] [R8]
      // blanking cycles carry zero so the display side has nothing to mistake for a pixel
      pin_word  <= (de_now && fifo_valid) ? fifo_data : 24'h000000; // see [R11]
    end
  end

  // sticky underrun: an active pixel found the buffer empty; cleared by device reset request
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      underrun_o <= 1'b0;
    else if (tick && de_now && !fifo_valid)
      underrun_o <= 1'b1;
    else if (device_reset_req_i)
      underrun_o <= 1'b0;
  end

  // vsync edge timer restarts whenever the vsync pin is about to move
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      since_vs <= 20'hFFFFF;
    else if (tick && (vsync_now != pins_o.vsync))
      since_vs <= 20'h00000;
    else if (since_vs != 20'hFFFFF)
      since_vs <= since_vs + 20'h00001;
  end

  // stereo reference moves only in the quiet middle of the vsync-low interval
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      pin_stereo   <= 1'b0;
      since_stereo <= 20'hFFFFF;
    end
    else if (stereo_ok_to_change && !tick && (stereo_eye_i != pin_stereo)) // see [R9] [R10]
    begin
      pin_stereo   <= stereo_eye_i;
      since_stereo <= 20'h00000;
    end
    else if (since_stereo != 20'hFFFFF)
      since_stereo <= since_stereo + 20'h00001;
  end
endmodule // video_source_ctrl

// file: video_src_map.svh
// video source map: timing limits and counts for the parallel pixel port driver
// assumes a 200 MHz system clock; all counts derive from the figures below
`ifndef VIDEO_SRC_MAP_SVH
`define VIDEO_SRC_MAP_SVH

`define CLK_MHZ             200
`define RST_LOW_NS          1250
`define RST_LOW_CYC         ((`RST_LOW_NS * `CLK_MHZ + 999) / 1000)
`define STEREO_GUARD_US     1000
`define STEREO_GUARD_CYC    (`STEREO_GUARD_US * `CLK_MHZ)
`define HSW_MIN             12'h004
`define HSW_MAX             12'h080
`define HBP_MIN             12'h004
`define HFP_MIN             12'h008
`define VSW_MIN             12'h001
`define VBP_MIN             12'h002
`define VFP_MIN             12'h001
`define TVB_BASE            17'h00006
`define TVB_RATIO_MUL       17'h00008
`define PCLK_MAX_MHZ        155
`define PCLK_MIN_MHZ        1
`define PIXEL_BITS          24

`endif

// file: video_src_pkg.sv
// video source types: timing configuration and the pin bundle toward the display controller
// assumes video_src_map.svh for the numeric limits
package video_src_pkg;

  // one frame's timing as asked for by the user side
  typedef struct packed {
    logic [11:0] h_sync;
    logic [11:0] h_back;
    logic [11:0] h_active;
    logic [11:0] h_front;
    logic [11:0] v_sync;
    logic [11:0] v_back;
    logic [11:0] v_active;
    logic [11:0] v_front;
  } timing_cfg_type;

  // pins driven into the display controller's parallel port
  typedef struct packed {
    logic        pclk;
    logic        vsync;
    logic        hsync;
    logic        pixel_valid_in;
    logic [23:0] pixel_word_in;
    logic        stereo_frame_ref;
  } video_pins_type;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RUN
  } run_state_type;

endpackage

// file: pixel_fifo.sv
// pixel_fifo: small synchronous fifo with valid/ready on both sides
// assumes one clock; registered full flag drives in_ready_o
`timescale 1ns/1ps
module pixel_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic [WIDTH-1:0]      out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  initial
  begin
    if (DEPTH < 2 || WIDTH < 1) $error("pixel_fifo: DEPTH must be >= 2 and WIDTH >= 1");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;
  logic [AW:0]      next_count;

  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_data_o  = mem[rd_ptr];
  assign out_valid_o = (count != '0);
  assign next_count  = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  // storage writes need no reset
  always_ff @(posedge clk_i)
  begin
    if (push) mem[wr_ptr] <= in_data_i;
  end

  // pointers wrap at DEPTH, which need not be a power of two
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (push) wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (pop)  rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
    end
  end

  // ready registered from the next count so the source sees back-pressure without a comb path
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      count      <= '0;
      in_ready_o <= 1'b0;
    end
    else
    begin
      count      <= next_count;
      in_ready_o <= (next_count != (AW+1)'(DEPTH));
    end
  end
endmodule // pixel_fifo

// file: reset_pulser.sv
// reset_pulser: drives the display controller's active-low reset for a fixed minimum time
// assumes a request pulse from the owner; output is a flop
`timescale 1ns/1ps
module reset_pulser #(
  parameter int LOW_CYC = 250
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic req_i,
  output logic      hw_reset_n_o,
  output logic      busy_o
);
  initial
  begin
    if (LOW_CYC < 1 || LOW_CYC > 65535) $error("reset_pulser: LOW_CYC out of range");
  end

  logic [15:0] cnt;

  // low from our own reset and on each request, released after LOW_CYC cycles
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      cnt          <= 16'h0000;
      hw_reset_n_o <= 1'b0;
      busy_o       <= 1'b1;
    end
    else if (req_i)
    begin
      cnt          <= 16'h0000;
      hw_reset_n_o <= 1'b0;
      busy_o       <= 1'b1;
    end
    else if (!hw_reset_n_o)
    begin
      cnt <= cnt + 16'h0001;
      if (cnt == 16'(LOW_CYC - 1)) // see [R1]
      begin
        hw_reset_n_o <= 1'b1;
        busy_o       <= 1'b0;
      end
    end
  end
endmodule // reset_pulser

// file: video_source_ctrl_asserts.sv
// checker for the video source pins: sync widths, porches, stereo guard, reset width
// assumes a bind onto video_source_ctrl; time counts are in system clocks, lines and blank count hsync rises
`timescale 1ns/1ps
module video_source_ctrl_asserts #(
  parameter int PCLK_DIV         = 2,
  parameter int STEREO_GUARD_CYC = 200000
) (
  input wire logic                          clk_i,
  input wire logic                          rst_n_i,
  input wire video_src_pkg::timing_cfg_type cfg_i,
  input wire logic [11:0]                   display_used_lines_i,
  input wire video_src_pkg::video_pins_type pins_o,
  input wire logic                          hw_reset_n_o,
  input wire logic                          frame_start_o
);
  import video_src_pkg::*;
  logic [19:0] low_cnt, hs_cnt, rise_cnt, fall_cnt, st_cnt, vs_cnt;
  logic [19:0] used, ratio, tvb_min;
  logic [11:0] lines, blank;
  logic        vs_line, had_act;

  // pins are dont-care while the device is held in reset
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i || !hw_reset_n_o);

  // blanking floor: 6 lines plus the rounded-up ratio step, never below 8
  always_comb
  begin
    used    = (display_used_lines_i == 12'h000) ? 20'(cfg_i.v_active) : 20'(display_used_lines_i);
    ratio   = (20'h00008 * 20'(cfg_i.v_active) + used - 20'h00001) / used;
    tvb_min = 20'h00006 + ((ratio > 20'h00008) ? ratio : 20'h00008);
  end

  // time since each pin edge; 20 bits so idle stretches in a run never wrap
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      low_cnt  <= '0;
      hs_cnt   <= '0;
      rise_cnt <= '0;
      fall_cnt <= '1;
      st_cnt   <= '1;
      vs_cnt   <= '1;
      lines    <= '0;
      blank    <= '0;
      vs_line  <= 1'h0;
      had_act  <= 1'h0;
    end
    else
    begin
      low_cnt  <= hw_reset_n_o ? '0 : low_cnt + 20'h00001;
      hs_cnt   <= pins_o.hsync ? hs_cnt + 20'h00001 : '0;
      rise_cnt <= $rose(pins_o.hsync) ? 20'h00001 : rise_cnt + 20'h00001;
      fall_cnt <= $fell(pins_o.pixel_valid_in) ? 20'h00001 : fall_cnt + 20'h00001;
      st_cnt   <= $changed(pins_o.stereo_frame_ref) ? 20'h00001 : st_cnt + 20'h00001;
      vs_cnt   <= $changed(pins_o.vsync) ? 20'h00001 : vs_cnt + 20'h00001;
      lines    <= $rose(pins_o.vsync) ? 12'h001 : lines + 12'($rose(pins_o.hsync));
      blank    <= $fell(pins_o.pixel_valid_in) ? 12'h000 : blank + 12'($rose(pins_o.hsync));
      vs_line  <= $rose(pins_o.vsync) ? 1'h0 : (vs_line | $rose(pins_o.hsync));
      had_act  <= had_act | $fell(pins_o.pixel_valid_in);
    end
  end

  AST_RESET_LOW: assert property (disable iff (!rst_n_i) $rose(hw_reset_n_o) |-> low_cnt >= 250)
    else $error("device reset low too short");
  AST_VSYNC_WIDTH: assert property ($fell(pins_o.vsync) |-> vs_line || $rose(pins_o.hsync))
    else $error("vsync shorter than a line");
  AST_FRAME_START: assert property ($rose(pins_o.vsync) |-> $past(frame_start_o, PCLK_DIV))
    else $error("vsync rose without a frame start pulse");
  AST_VBACK: assert property ($rose(pins_o.pixel_valid_in) |-> lines >= 12'h003)
    else $error("vertical back porch short");
  AST_VFRONT: assert property ($rose(pins_o.vsync) && had_act |-> blank >= 12'h001)
    else $error("vertical front porch short");
  AST_VBLANK: assert property ($rose(pins_o.pixel_valid_in) && had_act && blank > 12'h001
    |-> 20'(blank) - 20'h00001 >= tvb_min)
    else $error("total vertical blanking short");
  AST_HSYNC_WIDTH: assert property ($fell(pins_o.hsync)
    |-> hs_cnt >= 4 * PCLK_DIV && hs_cnt <= 128 * PCLK_DIV)
    else $error("hsync width out of range");
  AST_HBACK: assert property ($rose(pins_o.pixel_valid_in) |-> rise_cnt >= 4 * PCLK_DIV)
    else $error("data enable too soon after hsync");
  AST_HFRONT: assert property ($rose(pins_o.hsync) && had_act |-> fall_cnt >= 8 * PCLK_DIV)
    else $error("hsync too soon after data enable");
  AST_STEREO_SETUP: assert property ($changed(pins_o.vsync) |-> st_cnt >= STEREO_GUARD_CYC)
    else $error("stereo change too close before vsync");
  AST_STEREO_HOLD: assert property ($changed(pins_o.stereo_frame_ref) |-> vs_cnt >= STEREO_GUARD_CYC)
    else $error("stereo change too close after vsync");
  AST_PIN_TICK: assert property ($changed(pins_o.pixel_valid_in) || $changed(pins_o.hsync) |-> !pins_o.pclk)
    else $error("pins moved away from the pixel clock fall");
  AST_BLANK_WORD: assert property (!pins_o.pixel_valid_in |-> pins_o.pixel_word_in == 24'h000000)
    else $error("pixel word nonzero in blanking");

  COV_ACTIVE: cover property ($rose(pins_o.pixel_valid_in) && had_act);
  COV_STEREO: cover property ($changed(pins_o.stereo_frame_ref));
  COV_RESET: cover property ($rose(hw_reset_n_o));
endmodule // video_source_ctrl_asserts

// file: display_port_model.sv
// display port model: the controller input that samples the video pins
// assumes pins from video_source_ctrl; the bench reads got, frames and rst_bad
`timescale 1ns/1ps
module display_port_model (
  input wire video_src_pkg::video_pins_type pins_i,
  input wire logic                          hw_reset_n_i
);
  import video_src_pkg::*;
  logic [23:0] got[$];
  int          frames  = 0;
  logic        rst_bad = 1'h0;
  realtime     t_low   = 0.0;

  // words are taken on the pixel clock rise only while data-enable is high
  always @(posedge pins_i.pclk)
  begin
    if (hw_reset_n_i === 1'h1 && pins_i.pixel_valid_in === 1'h1)
      got.push_back(pins_i.pixel_word_in);
  end

  // a frame starts at each vertical sync rise
  always @(posedge pins_i.vsync)
  begin
    frames++;
  end

  // a shorter reset pulse would be ignored, so the device would keep old state
  always @(negedge hw_reset_n_i)
  begin
    t_low = $realtime;
  end

  always @(posedge hw_reset_n_i)
  begin
    if ($realtime - t_low < 1250.0)
      rst_bad = 1'h1;
  end
endmodule // display_port_model

// file: tb_video_source_ctrl.sv
// bench for video_source_ctrl: buffer fill, one frame, stereo flip with underrun
// assumes a 200 MHz clock and a shortened stereo guard of 200 clocks
`timescale 1ns/1ps
module tb_video_source_ctrl;
  import video_src_pkg::*;
  logic           clk_i                = 1'h0;
  logic           rst_n_i              = 1'h0;
  logic           enable_i             = 1'h0;
  logic           device_reset_req_i   = 1'h0;
  timing_cfg_type cfg_i                = '{12'h004, 12'h004, 12'h004, 12'h008, 12'h001, 12'h002, 12'h004, 12'h001};
  logic [11:0]    display_used_lines_i = 12'h002;
  logic [23:0]    pix_word_i           = 24'h000000;
  logic           pix_valid_i          = 1'h0;
  logic           stereo_eye_i         = 1'h0;
  logic           pix_ready_o;
  logic           hw_reset_n_o;
  logic           underrun_o;
  logic           frame_start_o;
  video_pins_type pins_o;
  int             err_count            = 0;
  int             cmp_count            = 0;

  video_source_ctrl #(
    .PCLK_DIV         (2),
    .FIFO_DEPTH       (4),
    .STEREO_GUARD_CYC (200)
  ) dut (
    .clk_i                (clk_i),
    .rst_n_i              (rst_n_i),
    .enable_i             (enable_i),
    .device_reset_req_i   (device_reset_req_i),
    .cfg_i                (cfg_i),
    .display_used_lines_i (display_used_lines_i),
    .pix_word_i           (pix_word_i),
    .pix_valid_i          (pix_valid_i),
    .pix_ready_o          (pix_ready_o),
    .stereo_eye_i         (stereo_eye_i),
    .pins_o               (pins_o),
    .hw_reset_n_o         (hw_reset_n_o),
    .underrun_o           (underrun_o),
    .frame_start_o        (frame_start_o)
  );

  display_port_model m (
    .pins_i       (pins_o),
    .hw_reset_n_i (hw_reset_n_o)
  );

  // free-running system clock
  initial
  begin
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    if (err_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic lost();
    err_count++;
    $display("Error %0t: wait ran out", $time);
    test_done();
  endtask

  // hold the word until the buffer takes it; ready is read at the falling edge to avoid a race
  task automatic push(input logic [23:0] w);
    int n;
    pix_word_i  <= w;
    pix_valid_i <= 1'h1;
    @(negedge clk_i);
    for (n = 0; n < 5000 && pix_ready_o !== 1'h1; n++) @(negedge clk_i);
    if (pix_ready_o !== 1'h1) lost();
    @(posedge clk_i);
  endtask

  task automatic wait_dev_up();
    int n;
    for (n = 0; n < 2000 && hw_reset_n_o !== 1'h1; n++) @(negedge clk_i);
    if (hw_reset_n_o !== 1'h1) lost();
  endtask

  // reset values, then fill the buffer while the device is still held in reset
  task automatic reset_and_fill();
    int  n;
    time t_rel;
    @(negedge clk_i);
    check(pins_o, 32'h00000000);
    check(hw_reset_n_o, 1'h0);
    @(posedge clk_i);
    rst_n_i <= 1'h1;
    t_rel = $time;
    // ready rises at the first edge that sees reset released
    repeat (2) @(negedge clk_i);
    check(pix_ready_o, 1'h1);
    @(posedge clk_i);
    for (n = 0; n < 4; n++) push(24'h5A0000 + 24'(n));
    pix_valid_i <= 1'h0;
    repeat (2) @(negedge clk_i);
    check(pix_ready_o, 1'h0);
    wait_dev_up();
    check(($time - t_rel) / 5 + 6 >= 250, 1'h1);
  endtask

  // enable drops mid-frame, so exactly one frame of sixteen words goes out
  task automatic one_frame();
    int n;
    @(posedge clk_i);
    enable_i <= 1'h1;
    for (n = 4; n < 16; n++) push(24'h5A0000 + 24'(n));
    pix_valid_i <= 1'h0;
    enable_i    <= 1'h0;
    for (n = 0; n < 5000 && m.got.size() < 16; n++) @(negedge clk_i);
    if (m.got.size() < 16) lost();
    for (n = 0; n < 16; n++) check(m.got[n], 24'h5A0000 + 24'(n));
    repeat (3000) @(negedge clk_i);
    check(m.got.size(), 16);
    check(m.frames, 1);
    check(underrun_o, 1'h0);
  endtask

  // stereo flip on an empty buffer, then a device reset that aborts the frame in the horizontal front porch of its last active line,
  // where no active pixel can set underrun again in the clearing cycle
  task automatic stereo_underrun();
    int n;
    @(posedge clk_i);
    stereo_eye_i <= 1'h1;
    enable_i     <= 1'h1;
    for (n = 0; n < 20000 && !(pins_o.stereo_frame_ref === 1'h1 && m.got.size() >= 32
         && pins_o.pixel_valid_in === 1'h0); n++) @(negedge clk_i);
    if (n >= 20000) lost();
    check(pins_o.stereo_frame_ref, 1'h1);
    check(underrun_o, 1'h1);
    check(m.got.size(), 32);
    check(m.got[m.got.size() - 1], 24'h000000);
    @(posedge clk_i);
    enable_i           <= 1'h0;
    device_reset_req_i <= 1'h1;
    @(posedge clk_i);
    device_reset_req_i <= 1'h0;
    repeat (2) @(negedge clk_i);
    check(underrun_o, 1'h0);
    check(hw_reset_n_o, 1'h0);
    wait_dev_up();
    check(m.rst_bad, 1'h0);
  endtask

  // reset is held for six clocks from time zero
  initial
  begin
    repeat (5) @(posedge clk_i);
    reset_and_fill();
    one_frame();
    stereo_underrun();
    test_done();
  end
endmodule // tb_video_source_ctrl

bind video_source_ctrl video_source_ctrl_asserts #(
  .PCLK_DIV         (PCLK_DIV),
  .STEREO_GUARD_CYC (STEREO_GUARD_CYC)
) chk (
  .clk_i                (clk_i),
  .rst_n_i              (rst_n_i),
  .cfg_i                (cfg_i),
  .display_used_lines_i (display_used_lines_i),
  .pins_o               (pins_o),
  .hw_reset_n_o         (hw_reset_n_o),
  .frame_start_o        (frame_start_o)
);
